// *** pkg/codec_params.svh ***
// Constants for the codec rate and control block: timing, field positions, resets.
// Assumes the including file is SystemVerilog and the system clock runs at the rate below.
`ifndef CODEC_PARAMS_SVH
`define CODEC_PARAMS_SVH
// System clock rate in MHz.
`define CLK_SYS_MHZ 50
// Settling time of one calibration cycle in ns.
`define CAL_TIME_NS 20000
// Calibration length in clock cycles, rounded down.
`define CAL_CYCLES ((`CAL_TIME_NS * `CLK_SYS_MHZ) / 1000)
// Bit clock periods summed into one measurement.
`define MEAS_EDGES 16
// Shift that divides the summed count by the edge count.
`define MEAS_SHIFT 4
// Least and largest legal clock ratio.
`define RATIO_MIN 12'h004
`define RATIO_MAX 12'h100
// Period count at which the bit clock is taken as lost.
`define MCOUNT_MAX 12'hfff
// Control word reset value and the interrupt mask bit position.
`define CTRL_RESET 32'h0000_0000
`define CF_MASK 0
// Bit count that opens the status byte, and the bit that ends the frame.
`define STATUS_FIRST 6'h18
`define STATUS_LAST 6'h1f
`endif

// *** pkg/codec_pkg.sv ***
// Types shared by the codec rate and control block.
// Assumes compilation before any design file.
package codec_pkg;
    // Serial modes present in this device; modes one and two do not exist.
    typedef enum logic [1:0] {MODE_THREE, MODE_THREE_MULT, MODE_FOUR, MODE_FIVE} serial_mode_t;
    // Calibration sequencer states.
    typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;
    // Converter flags and digital input that raise events.
    typedef struct packed {
        logic conversion_status_flag;
        logic digital_input_bit_one;
        logic left_clip_flag;
        logic right_clip_flag;
    } flags_t;
    // Status byte shifted out at the end of a control frame.
    typedef struct packed {
        flags_t flags;
        logic rate_error;
        logic calibrating;
        logic irq_pending;
        logic master;
    } status_t;
endpackage : codec_pkg

// *** rtl/codec_serial_rate_control.sv ***
// Rate measurement, calibration sequencing and mode-four control port of the codec.
// Assumes the host launches chip select and control data on the bit clock, and that
// clk_sys_i is the master clock input; both clocks share the reset rstn_i.
`timescale 1ns/1ps
`include "codec_params.svh"

// Single-clock word FIFO with valid and ready on both sides.
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Fill side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // Depth must be a power of two so the pointers wrap by themselves.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("word_fifo: DEPTH must be a power of two, at least 2.");
    end

    // Whole FIFO state, memory included.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] used;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    // Full and empty come from the occupancy count, never guessed.
    assign in_ready_o = (st.used != DEPTH[AW:0]);
    assign out_valid_o = (st.used != '0);
    assign out_data_o = st.mem[st.rd];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_i;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.used = st.used + 1'b1;
        end else if (pop && !push) begin
            next_st.used = st.used - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : word_fifo

// Top: rate control and control port.
module codec_serial_rate_control #(
    parameter int FIFO_DEPTH = 16
) (
    // Master clock and reset.
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Serial bit clock, the link domain.
    input wire logic bit_clk_i,
    // Control port, launched on the bit clock.
    input wire logic control_chip_select_i,
    input wire logic control_data_i,
    output logic control_data_o,
    // Mode and rate pins.
    input wire codec_pkg::serial_mode_t serial_mode_i,
    input wire logic master_submode_i,
    input wire logic rate_select_bit_one_i,
    input wire logic rate_select_bit_two_i,
    input wire logic rate_select_bit_three_i,
    // Converter flags and digital input.
    input wire codec_pkg::flags_t flags_i,
    // Control word and rate status.
    output logic [31:0] control_word_o,
    output logic [11:0] rate_ratio_o,
    output logic calibrating_o,
    output logic rate_error_o,
    // Open-drain interrupt, active low.
    output logic int_n_o,
    output logic int_n_oe_n_o
);
    import codec_pkg::*;

    // Cycle count of one calibration, sized for the counter.
    localparam logic [15:0] CAL_LEN = 16'(`CAL_CYCLES);

    if (FIFO_DEPTH < 2) begin : g_bad_fifo
        $error("codec_serial_rate_control: FIFO_DEPTH must be at least 2.");
    end

    // Bit clock domain state.
    typedef struct packed {
        logic cs_q;          // Chip select seen at the last edge.
        logic [5:0] bitcnt;  // Bits shifted in this frame.
        logic [31:0] shift;  // Incoming control bits.
        logic [31:0] word;   // Latched word, stable until next frame.
        logic word_tgl;      // Flips once per latched word.
        logic edge_tgl;      // Flips on every rising bit clock edge.
        logic st_s1;         // Status request synchroniser.
        logic st_s2;
        logic st_ack;        // Status handshake answer.
        status_t st_word;    // Status byte copy for shifting out.
        logic dout;          // Control output bit.
    } link_state_t;

    // Master clock domain state.
    typedef struct packed {
        logic edge_s1, edge_s2, edge_q;
        logic wt_s1, wt_s2, wt_q;
        logic sa_s1, sa_s2;
        logic st_tgl;
        status_t st_hold;
        logic [2:0] rate_s1, rate_s2;
        logic [1:0] mode_s1, mode_s2;
        logic master_s1, master_s2;
        flags_t flag_s1, flag_s2, flag_q;
        logic [1:0] warm;    // Cycles since reset, until the flag synchroniser has filled.
        logic [11:0] mcount;
        logic [3:0] medges;
        logic [15:0] macc;
        logic [11:0] meas;
        logic [11:0] rate;
        logic err;
        cal_state_t cal;
        logic [15:0] cal_cnt;
        logic irq;
        logic pend;
        logic [31:0] pend_word;
        logic [31:0] ctrl;
    } sys_state_t;

    link_state_t ln;
    link_state_t next_ln;
    sys_state_t sy;
    sys_state_t next_sy;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [31:0] fifo_out_data;

    // Control words queue here so a word never lands mid-calibration.
    word_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_ctrl_fifo (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .in_valid_i(sy.pend),
        .in_ready_o(fifo_in_ready),
        .in_data_i(sy.pend_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(sy.cal == CAL_IDLE),
        .out_data_o(fifo_out_data)
    );

    // Link side: shifting, latching and status output on the bit clock.
    always_comb begin
        next_ln = ln;
        next_ln.edge_tgl = !ln.edge_tgl;
        next_ln.cs_q = control_chip_select_i;
        next_ln.st_s1 = sy.st_tgl;
        next_ln.st_s2 = ln.st_s1;
        next_ln.dout = 1'b0;
        if (!control_chip_select_i) begin
            next_ln.shift = {ln.shift[30:0], control_data_i};
            if (ln.bitcnt != 6'h3f) begin
                next_ln.bitcnt = ln.bitcnt + 6'h01;
            end
            if (ln.bitcnt >= `STATUS_FIRST && ln.bitcnt <= `STATUS_LAST) begin
                next_ln.dout = ln.st_word[3'(`STATUS_LAST - ln.bitcnt)];
            end
        end else begin
            next_ln.bitcnt = '0;
            // Status is refreshed only between frames so a byte never tears.
            if (ln.st_s2 != ln.st_ack) begin
                next_ln.st_word = sy.st_hold;
                next_ln.st_ack = ln.st_s2;
            end
            if (!ln.cs_q) begin
                next_ln.word = ln.shift;
                next_ln.word_tgl = !ln.word_tgl;
            end
        end
    end

    // Link state register.
    always_ff @(posedge bit_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ln <= '0;
        end else begin
            ln <= next_ln;
        end
    end

    // Master clock side: measurement, rate, calibration, events and control.
    always_comb begin
        logic [15:0] total;
        logic [11:0] ratio;
        logic set_evt;
        logic rd_evt;
        total = '0;
        ratio = '0;
        set_evt = 1'b0;
        rd_evt = 1'b0;
        next_sy = sy;
        // Two-flop synchronisers for every foreign input but the latched word, which the word toggle qualifies.
        next_sy.edge_s1 = ln.edge_tgl;
        next_sy.edge_s2 = sy.edge_s1;
        next_sy.edge_q = sy.edge_s2;
        next_sy.wt_s1 = ln.word_tgl;
        next_sy.wt_s2 = sy.wt_s1;
        next_sy.wt_q = sy.wt_s2;
        next_sy.sa_s1 = ln.st_ack;
        next_sy.sa_s2 = sy.sa_s1;
        next_sy.rate_s1 = {rate_select_bit_three_i, rate_select_bit_two_i, rate_select_bit_one_i};
        next_sy.rate_s2 = sy.rate_s1;
        next_sy.mode_s1 = serial_mode_i;
        next_sy.mode_s2 = sy.mode_s1;
        next_sy.master_s1 = master_submode_i;
        next_sy.master_s2 = sy.master_s1;
        next_sy.flag_s1 = flags_i;
        next_sy.flag_s2 = sy.flag_s1;
        next_sy.flag_q = sy.flag_s2;

        if (sy.mcount != `MCOUNT_MAX) begin
            next_sy.mcount = sy.mcount + 12'h001;
        end else begin
            // Bit clock lost: flag the error and restart the sum.
            next_sy.err = 1'b1;
            next_sy.macc = '0;
            next_sy.medges = '0;
        end
        if (sy.edge_s2 != sy.edge_q) begin
            next_sy.mcount = 12'h001;
            total = sy.macc + 16'(sy.mcount);
            if (sy.medges == 4'(`MEAS_EDGES - 1)) begin
                next_sy.macc = '0;
                next_sy.medges = '0;
                if (serial_mode_t'(sy.mode_s2) == MODE_THREE_MULT) begin
                    // Saturate so that a wrapped sum never passes as a legal ratio.
                    ratio = (total > 16'h0fff) ? 12'hfff : total[11:0];
                end else begin
                    ratio = 12'(total >> `MEAS_SHIFT);
                end
                next_sy.meas = ratio;
                // Only two equal readings in a row are trusted.
                if (ratio == sy.meas) begin
                    next_sy.err = (ratio < `RATIO_MIN) || (ratio > `RATIO_MAX);
                    if (!sy.master_s2 && !next_sy.err && ratio != sy.rate) begin
                        next_sy.rate = ratio;
                    end
                end
            end else begin
                next_sy.macc = total;
                next_sy.medges = sy.medges + 4'h1;
            end
        end
        if (sy.master_s2) begin
            next_sy.rate = {9'h000, sy.rate_s2};
        end

        if (next_sy.rate != sy.rate) begin
            next_sy.cal = CAL_RUN;
            next_sy.cal_cnt = '0;
        end else begin
            case (sy.cal)
                CAL_RUN: begin
                    if (sy.cal_cnt >= CAL_LEN - 16'h0001) begin
                        next_sy.cal = CAL_IDLE;
                    end else begin
                        next_sy.cal_cnt = sy.cal_cnt + 16'h0001;
                    end
                end
                default: begin
                    next_sy.cal_cnt = '0;
                end
            endcase
        end

        // control port only in mode four.
        if (sy.wt_s2 != sy.wt_q && serial_mode_t'(sy.mode_s2) == MODE_FOUR) begin
            rd_evt = 1'b1;
            // A word arriving while one still waits replaces it.
            next_sy.pend = 1'b1;
            next_sy.pend_word = ln.word;
        end else if (sy.pend && fifo_in_ready) begin
            next_sy.pend = 1'b0;
        end
        // Words are applied only outside calibration.
        if (fifo_out_valid && sy.cal == CAL_IDLE) begin
            next_sy.ctrl = fifo_out_data;
        end

        // Flag edges are ignored until the synchroniser has filled, so that a level present at
        // reset never looks like an event; a flag that moves after the first sample is still seen.
        if (sy.warm != 2'h3) begin
            next_sy.warm = sy.warm + 2'h1;
        end
        set_evt = ((sy.warm == 2'h3) &&
                   ((sy.flag_s2.conversion_status_flag != sy.flag_q.conversion_status_flag) ||
                    (sy.flag_s2.digital_input_bit_one != sy.flag_q.digital_input_bit_one) ||
                    (sy.flag_s2.left_clip_flag && !sy.flag_q.left_clip_flag) ||
                    (sy.flag_s2.right_clip_flag && !sy.flag_q.right_clip_flag))) ||
                  (sy.err && !next_sy.err);
        if (set_evt && !sy.ctrl[`CF_MASK]) begin
            next_sy.irq = 1'b1;
        end else if (rd_evt) begin
            next_sy.irq = 1'b0;
        end

        // Status handshake: a new byte is offered once the last one was taken.
        if (sy.sa_s2 == sy.st_tgl) begin
            next_sy.st_hold = '{flags: sy.flag_s2, rate_error: sy.err,
                                calibrating: sy.cal == CAL_RUN,
                                irq_pending: sy.irq, master: sy.master_s2};
            next_sy.st_tgl = !sy.st_tgl;
        end
    end

    // System state register; reset starts a calibration.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sy <= '0;
            sy.cal <= CAL_RUN;
            sy.ctrl <= `CTRL_RESET;
        end else begin
            sy <= next_sy;
        end
    end

    // Outputs straight from state flip-flops, save int_n_o, which is tied low.
    assign control_data_o = ln.dout;
    assign control_word_o = sy.ctrl;
    assign rate_ratio_o = sy.rate;
    assign calibrating_o = (sy.cal == CAL_RUN);
    assign rate_error_o = sy.err;
    assign int_n_o = 1'b0;
    assign int_n_oe_n_o = !sy.irq;
endmodule : codec_serial_rate_control

// *** testbench/codec_chk.sv ***
// Checker for the codec rate and control block; it sees only the top ports.
// Assumes one master clock domain; the bit clock is only sampled for a stall count.
`timescale 1ns/1ps
`include "codec_params.svh"
module codec_chk (
    // Clocks and reset.
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic bit_clk_i,
    // Control port.
    input wire logic control_chip_select_i,
    input wire logic control_data_i,
    input wire logic control_data_o,
    // Mode, rate and flag pins.
    input wire codec_pkg::serial_mode_t serial_mode_i,
    input wire logic master_submode_i,
    input wire logic rate_select_bit_one_i,
    input wire logic rate_select_bit_two_i,
    input wire logic rate_select_bit_three_i,
    input wire codec_pkg::flags_t flags_i,
    // Status outputs.
    input wire logic [31:0] control_word_o,
    input wire logic [11:0] rate_ratio_o,
    input wire logic calibrating_o,
    input wire logic rate_error_o,
    input wire logic int_n_o,
    input wire logic int_n_oe_n_o
);
    import codec_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Cycles the sampled bit clock has stood still, and its last sample.
    int stall;
    logic bit_last;
    // Any move of the bit clock restarts the stall count.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall <= 0;
            bit_last <= 1'b0;
        end else begin
            stall <= (bit_clk_i == bit_last) ? stall + 1 : 0;
            bit_last <= bit_clk_i;
        end
    end
    // Master sub-mode with the rate pins still for six cycles, which covers the synchroniser.
    sequence pins_steady;
        (master_submode_i && $stable({rate_select_bit_three_i, rate_select_bit_two_i, rate_select_bit_one_i}))[*6];
    endsequence
    // A mode-four frame ends with select rising while the flags stay put.
    sequence frame_end;
        $rose(control_chip_select_i) && serial_mode_i == MODE_FOUR && $stable(flags_i);
    endsequence
    a_reset_word_zero: assert property ($rose(rstn_i) |-> control_word_o == `CTRL_RESET)
        else $error("control word not clear after reset");
    a_reset_cal_start: assert property ($rose(rstn_i) |-> calibrating_o [*8])
        else $error("no calibration after reset");
    a_rate_change_cal: assert property ($changed(rate_ratio_o) |-> ##[0:2] calibrating_o)
        else $error("rate change without calibration");
    a_lost_clock_error: assert property (stall > 4200 && !master_submode_i |-> rate_error_o)
        else $error("stopped bit clock not flagged");
    a_master_pin_rate: assert property (pins_steady |->
        rate_ratio_o == {9'h000, rate_select_bit_three_i, rate_select_bit_two_i, rate_select_bit_one_i})
        else $error("master rate differs from pins");
    a_word_mode_four: assert property ($changed(control_word_o) |-> serial_mode_i == MODE_FOUR)
        else $error("control word changed outside mode four");
    a_read_releases: assert property (frame_end |-> ##[2:10] int_n_oe_n_o)
        else $error("interrupt kept after control read");
    a_masked_no_irq: assert property ($fell(int_n_oe_n_o) |-> !$past(control_word_o[`CF_MASK]))
        else $error("interrupt raised while masked");
    a_int_data_low: assert property (int_n_o == 1'b0)
        else $error("interrupt pin data not low");
endmodule : codec_chk
bind codec_serial_rate_control codec_chk codec_chk_inst (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bit_clk_i(bit_clk_i),
    .control_chip_select_i(control_chip_select_i), .control_data_i(control_data_i),
    .control_data_o(control_data_o), .serial_mode_i(serial_mode_i), .master_submode_i(master_submode_i),
    .rate_select_bit_one_i(rate_select_bit_one_i), .rate_select_bit_two_i(rate_select_bit_two_i),
    .rate_select_bit_three_i(rate_select_bit_three_i), .flags_i(flags_i), .control_word_o(control_word_o),
    .rate_ratio_o(rate_ratio_o), .calibrating_o(calibrating_o), .rate_error_o(rate_error_o),
    .int_n_o(int_n_o), .int_n_oe_n_o(int_n_oe_n_o)
);

// *** testbench/host_model.sv ***
// Host model: makes the bit clock and runs mode-four control frames.
// Assumes the bench sets the half period and the run flag.
`timescale 1ns/1ps
module host_model (
    // Serial side towards the codec.
    output logic bit_clk_o,
    output logic select_o,
    output logic data_o,
    input wire logic status_i
);
    // Half period in ns; clearing run stops the clock to fake a lost link.
    real half_ns = 7.5;
    logic run = 1'b1;
    // Idle levels.
    initial begin
        bit_clk_o = 1'b0;
        select_o = 1'b1;
        data_o = 1'b0;
    end
    // ratio via period
    // The host picks the clock ratio through the half period.
    always begin
        #(half_ns);
        if (run) bit_clk_o = ~bit_clk_o;
    end
    // frame and readback
    // Thirty-two bits MSB first, then one high edge latches; the last eight samples are status.
    task automatic send_frame(input logic [31:0] word, output logic [7:0] status);
        int i;
        status = 8'h00;
        @(negedge bit_clk_o);
        select_o = 1'b0;
        data_o = word[31];
        for (i = 30; i >= -1; i--) begin
            @(posedge bit_clk_o);
            status = {status[6:0], status_i};
            @(negedge bit_clk_o);
            if (i >= 0) data_o = word[i];
            else select_o = 1'b1;
        end
        // A released line shows the inverse, never a stale bit.
        data_o = ~data_o;
        @(posedge bit_clk_o);
        status = {status[6:0], status_i};
        repeat (3) @(negedge bit_clk_o);
    endtask : send_frame
endmodule : host_model

// *** testbench/testbench.sv ***
// Self-checking bench for the codec rate and control block.
// Assumes the host model drives the link and the bench drives pins on the falling edge.
`timescale 1ns/1ps
module testbench;
    import codec_pkg::*;
    // Clock, reset and pins.
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    // mode pins driven
    // The mode pins have no pull, so the bench always drives a defined level on them.
    serial_mode_t mode = MODE_FOUR;
    logic master = 1'b0;
    logic [2:0] pins = 3'h0;
    flags_t flags = 4'h0;
    // Link wires and design outputs.
    logic bit_clk, sel, cdin, cdout, cal, rate_err, int_n, int_oe_n;
    logic [31:0] word;
    logic [11:0] ratio;
    logic [7:0] st;
    // The pull-up wins whenever the pin is not driven.
    wire int_pin = int_oe_n ? 1'b1 : int_n;
    // Score and word change counters.
    int checked = 0;
    int fail_count = 0;
    int changes = 0;
    logic [31:0] word_seen = 32'h0000_0000;
    always #10 clk_sys_i = ~clk_sys_i;
    codec_serial_rate_control codec_serial_rate_control_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bit_clk_i(bit_clk),
        .control_chip_select_i(sel), .control_data_i(cdin), .control_data_o(cdout),
        .serial_mode_i(mode), .master_submode_i(master), .rate_select_bit_one_i(pins[0]),
        .rate_select_bit_two_i(pins[1]), .rate_select_bit_three_i(pins[2]), .flags_i(flags),
        .control_word_o(word), .rate_ratio_o(ratio), .calibrating_o(cal), .rate_error_o(rate_err),
        .int_n_o(int_n), .int_n_oe_n_o(int_oe_n)
    );
    host_model host_model_inst (.bit_clk_o(bit_clk), .select_o(sel), .data_o(cdin), .status_i(cdout));
    // Counts each change of the applied word, so drained FIFO entries can be tallied.
    always @(negedge clk_sys_i) begin
        if (word !== word_seen) changes++;
        word_seen = word;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task close_out;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    task hang;
        fail_count++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask : hang
    // Bounded wait for a ratio; a new ratio must start calibration.
    task wait_ratio(input logic [11:0] exp);
        int n;
        for (n = 0; ratio !== exp; n++) begin
            if (n == 6000) hang();
            @(negedge clk_sys_i);
        end
        repeat (3) @(negedge clk_sys_i);
        check(cal, 1'b1);
    endtask : wait_ratio
    task wait_cal;
        int n;
        for (n = 0; cal !== 1'b0; n++) begin
            if (n == 3000) hang();
            @(negedge clk_sys_i);
        end
    endtask : wait_cal
    // Lost clock, then slave ratios; recovery from the error raises the interrupt.
    task t_rate;
        host_model_inst.run = 1'b0;
        repeat (4300) @(negedge clk_sys_i);
        check(rate_err, 1'b1);
        host_model_inst.half_ns = 80.0;
        host_model_inst.run = 1'b1;
        wait_ratio(12'h008);
        repeat (10) @(negedge clk_sys_i);
        check({rate_err, int_pin}, 2'b00);
        mode = MODE_THREE_MULT;
        wait_ratio(12'h080);
        mode = MODE_THREE;
        host_model_inst.half_ns = 240.0;
        wait_ratio(12'h018);
        $display("test rate done");
    endtask : t_rate
    task t_master;
        master = 1'b1;
        pins = 3'h5;
        host_model_inst.half_ns = 7.5;
        wait_ratio(12'h005);
        wait_cal();
        $display("test master done");
    endtask : t_master
    // Each event in turn, then its status readback and release; clip falls raise nothing.
    task t_irq;
        int k;
        mode = MODE_FOUR;
        repeat (5) @(negedge clk_sys_i);
        host_model_inst.send_frame(32'h0000_0000, st);
        repeat (10) @(negedge clk_sys_i);
        check(int_pin, 1'b1);
        for (k = 0; k < 8; k++) begin
            flags[3 - (k % 4)] = ~flags[3 - (k % 4)];
            repeat (10) @(negedge clk_sys_i);
            check(int_pin, k >= 6);
            host_model_inst.send_frame(32'h0000_0000, st);
            check({st[7:4], st[2:0]}, {flags, 1'b0, k < 6, 1'b1});
            repeat (10) @(negedge clk_sys_i);
            check(int_pin, 1'b1);
        end
        host_model_inst.send_frame(32'h0000_0001, st);
        repeat (10) @(negedge clk_sys_i);
        flags.conversion_status_flag = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        check(int_pin, 1'b1);
        $display("test interrupt done");
    endtask : t_irq
    task t_word;
        host_model_inst.send_frame(32'ha5c3_0f12, st);
        repeat (10) @(negedge clk_sys_i);
        check(word, 32'ha5c3_0f12);
        mode = MODE_FIVE;
        repeat (5) @(negedge clk_sys_i);
        host_model_inst.send_frame(32'h1234_5678, st);
        repeat (10) @(negedge clk_sys_i);
        check(word, 32'ha5c3_0f12);
        mode = MODE_FOUR;
        repeat (5) @(negedge clk_sys_i);
        $display("test word done");
    endtask : t_word
    // Eighteen words during calibration: sixteen queue, the seventeenth is overwritten.
    task t_fifo;
        int i;
        pins = 3'h3;
        repeat (8) @(negedge clk_sys_i);
        check(cal, 1'b1);
        changes = 0;
        for (i = 1; i <= 18; i++) begin
            host_model_inst.send_frame(32'h5a00_0000 | (i << 8), st);
        end
        check(cal, 1'b1);
        check(word, 32'ha5c3_0f12);
        wait_cal();
        repeat (40) @(negedge clk_sys_i);
        check(word, 32'h5a00_1200);
        check(changes, 17);
        // reset mid-run
        // A reset with a live word and a high flag pin must clear the word and raise no event.
        rstn_i = 1'b0;
        repeat (3) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        check(word, 32'h0000_0000);
        check(cal, 1'b1);
        repeat (10) @(negedge clk_sys_i);
        check(int_pin, 1'b1);
        check(ratio, 12'h003);
        $display("test fifo done");
    endtask : t_fifo
    // Main sequence after twenty reset cycles.
    initial begin
        repeat (20) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        check(word, 32'h0000_0000);
        check(int_pin, 1'b1);
        t_rate();
        t_master();
        t_irq();
        t_word();
        t_fifo();
        close_out();
    end
endmodule : testbench
